/* vih_map.vh */
// Register map, field positions, reset values and vector figures
// Assumes inclusion by bare name from the design files of this block
`ifndef VIH_MAP_VH
`define VIH_MAP_VH
// ==========================================================
// Register offsets (8-bit address space)
`define VIH_REQ_REG_ADDR    8'hfa
`define VIH_MASK_REG_ADDR   8'hfb
`define VIH_PRIO_REG_ADDR   8'hf9
`define VIH_PORT3_MODE_ADDR 8'hf7
`define VIH_PIN_STATE_ADDR  8'hf6
// ==========================================================
// Field positions
`define VIH_EDGE_REQ0_BIT   6
`define VIH_EDGE_REQ2_BIT   7
`define VIH_MASK_GLOBAL_BIT 7
`define VIH_P3M_ANALOG_BIT  1
// ==========================================================
// Reset values, source count and vector step
`define VIH_REQ_RESET       8'h00
`define VIH_MASK_RESET      8'h00
`define VIH_PRIO_RESET      8'h00
`define VIH_P3M_RESET       8'h00
`define VIH_NUM_SRC         6
`define VIH_VEC_STEP        16'h0002
`endif

/* vih_edge_det.v */
// One request edge detector with programmable rising and falling sense
// Assumes the input is synchronous to clk_sys
`timescale 1ns/100ps
module vih_edge_det (
  input  wire clk_sys,
  input  wire rst_sync_n,
  input  wire sig_in,
  input  wire sense_rise,
  input  wire sense_fall,
  output wire edge_hit
);
  reg sig_prev;
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sig_prev <= 1'b1;
    end else begin
      sig_prev <= sig_in;
    end
  end
  assign edge_hit = (sense_rise & sig_in & ~sig_prev) | (sense_fall & ~sig_in & sig_prev);
endmodule

/* vih_prio_enc.v */
// Programmable priority encoder over six pending requests
// Assumes a one-hot-free request vector; answers combinationally
`timescale 1ns/100ps
module vih_prio_enc (
  input  wire [5:0] pend,
  input  wire [2:0] prio_sel,
  output reg        any_hit,
  output reg  [2:0] winner
);
  // ==========================================================
  // Priority order: prio_sel rotates the start point of the search
  integer k;
  reg [2:0] idx;
  reg [3:0] sum;
  reg [3:0] rem;
  always @* begin
    any_hit = 1'b0;
    winner  = 3'd0;
    idx     = 3'd0;
    sum     = 4'd0;
    rem     = 4'd0;
    for (k = 5; k >= 0; k = k - 1) begin
      // Four bits so start plus index cannot wrap before the modulo
      sum = {1'b0, k[2:0]} + {1'b0, prio_sel};
      rem = sum % 4'd6;
      idx = rem[2:0];
      if (pend[idx]) begin
        any_hit = 1'b1;
        winner  = idx;
      end
    end
  end
endmodule

/* vih_ctrl.v */
// Vectored interrupt controller with halt wake-up
// Assumes a core sequencer that handshakes vector fetches, and synchronous pins
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`include "vih_map.vh"
// Operation
// - Six requests, individually and globally maskable
// - Port3 mode bit 1 picks request one
// - Request zero from port3_2, vector 0,1
// - Request one falling edge, vector 2,3
// - Request two from port3_1, vector 4,5
// - Timers and low voltage use 6..11
// - Priority register steers pending selection
// - Grant disables interrupts, saves context
// - Fetch 16-bit service address, then branch
// - Pending register stays readable while masked
// - Analog comparators raise requests two, zero
// - Request register D7 D6 select edges
// - Edge pin levels readable by software
// - Halt stops cpu clock, sources live
// - Halt ends only on taken interrupt
module vih_ctrl (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        port3_1,
  input  wire        port3_2,
  input  wire        port3_3,
  input  wire        stop_recovery_out,
  input  wire        analog_in_one,
  input  wire        analog_in_two,
  input  wire        wide_timer,
  input  wire        narrow_timer,
  input  wire        low_voltage_detect,
  input  wire        halt_req,
  input  wire        iret_done,
  input  wire        ack_step,
  input  wire [7:0]  prog_data,
  output reg  [15:0] prog_addr,
  output reg         prog_rd,
  output reg         save_ctx,
  output reg         branch_go,
  output reg  [15:0] branch_addr,
  output reg         cpu_clk_en,
  output reg         int_active
);
  // ==========================================================
  // Reset release
  // Every flop leaves reset on the same edge, whatever the phase of rst_n
  reg rst_meta;
  reg rst_sync_n;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ==========================================================
  // Registers
  reg [7:0] req_reg;
  reg [7:0] mask_reg;
  reg [7:0] prio_reg;
  reg [7:0] port3_mode_reg;
  reg       glob_en;

  // ==========================================================
  // Request sources
  // Pins are taken as synchronous; no glitch filter in front of the detectors
  wire src1;
  wire req2_src;
  wire req0_src;
  wire [5:0] hit;
  assign src1 = port3_mode_reg[`VIH_P3M_ANALOG_BIT] ? stop_recovery_out : port3_3;
  // Comparator events fold onto the shared edge requests
  assign req2_src = port3_1 & analog_in_one;
  assign req0_src = port3_2 & analog_in_two;

  wire [1:0] esel;
  wire       rise0;
  wire       fall0;
  wire       rise2;
  wire       fall2;
  assign esel = req_reg[`VIH_EDGE_REQ2_BIT:`VIH_EDGE_REQ0_BIT];
  // Request zero follows D6 for rising, request two follows D7
  assign rise0 = esel[0];
  assign fall0 = ~esel[0] | esel[1];
  assign rise2 = esel[1];
  assign fall2 = ~esel[1] | esel[0];

  // Edge sense per request: 00 FF, 01 F/R, 10 R/F, 11 both
  vih_edge_det u_edge0 (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .sig_in     (req0_src),
    .sense_rise (rise0),
    .sense_fall (fall0),
    .edge_hit   (hit[0])
  );
  vih_edge_det u_edge1 (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .sig_in     (src1),
    .sense_rise (1'b0),
    .sense_fall (1'b1),
    .edge_hit   (hit[1])
  );
  vih_edge_det u_edge2 (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .sig_in     (req2_src),
    .sense_rise (rise2),
    .sense_fall (fall2),
    .edge_hit   (hit[2])
  );
  // Timer and detector requests are one-cycle pulses from their blocks
  assign hit[3] = wide_timer;
  assign hit[4] = narrow_timer;
  assign hit[5] = low_voltage_detect;

  // ==========================================================
  // Arbitration
  // A flag counts only with its own mask bit, bit 7 and no service running
  wire [5:0] eligible;
  wire       any_hit;
  wire [2:0] winner;
  assign eligible = req_reg[5:0] & mask_reg[5:0] & {6{mask_reg[`VIH_MASK_GLOBAL_BIT] & glob_en}};
  vih_prio_enc u_prio (
    .pend     (eligible),
    .prio_sel (prio_reg[2:0]),
    .any_hit  (any_hit),
    .winner   (winner)
  );

  // ==========================================================
  // Interrupt machine cycle
  localparam ST_RUN   = 6'b000001;
  localparam ST_SAVE  = 6'b000010;
  localparam ST_HI    = 6'b000100;
  localparam ST_LO    = 6'b001000;
  localparam ST_JUMP  = 6'b010000;
  localparam ST_HALT  = 6'b100000;
  reg [5:0]  state;
  reg [5:0]  next_state;
  reg [2:0]  serve_id;
  reg [7:0]  vec_hi;
  reg [5:0]  clr_mask;
  wire [15:0] vec_base;
  assign vec_base = {12'h000, serve_id, 1'b0};

  // Step strobes of the machine cycle; save, high and low steps are gated by the core's handshake, grant and halt entry are not
  wire grant;
  wire halt_enter;
  wire save_step;
  wire hi_step;
  wire lo_step;
  assign grant      = (state == ST_RUN || state == ST_HALT) && any_hit;
  assign halt_enter = (state == ST_RUN) && halt_req && !any_hit;
  assign save_step  = (state == ST_SAVE) && ack_step;
  assign hi_step    = (state == ST_HI) && ack_step;
  assign lo_step    = (state == ST_LO) && ack_step;

  always @* begin
    next_state = state;
    case (state)
      ST_RUN:  begin
        if (any_hit) next_state = ST_SAVE;
        else if (halt_req) next_state = ST_HALT;
      end
      ST_HALT: begin
        if (any_hit) next_state = ST_SAVE;
      end
      ST_SAVE: begin
        if (ack_step) next_state = ST_HI;
      end
      ST_HI:   begin
        if (ack_step) next_state = ST_LO;
      end
      ST_LO:   begin
        if (ack_step) next_state = ST_JUMP;
      end
      ST_JUMP: next_state = ST_RUN;
      default: next_state = ST_RUN;
    endcase
  end

  // Only the served flag drops; the others wait their turn
  always @* begin
    clr_mask = 6'h00;
    if (state == ST_HI && ack_step) clr_mask[serve_id] = 1'b1;
  end

  // ==========================================================
  // State register
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Grant: everything stays masked until the routine returns
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      serve_id   <= 3'd0;
      glob_en    <= 1'b1;
      int_active <= 1'b0;
      save_ctx   <= 1'b0;
    end else begin
      save_ctx <= grant;
      if (grant) begin
        serve_id   <= winner;
        glob_en    <= 1'b0;
        int_active <= 1'b1;
      end else if (iret_done) begin
        glob_en    <= 1'b1;
        int_active <= 1'b0;
      end
    end
  end

  // ==========================================================
  // CPU clock gate
  // Only a taken request reopens the clock; a masked one leaves the core asleep
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cpu_clk_en <= 1'b1;
    end else if (grant) begin
      cpu_clk_en <= 1'b1;
    end else if (halt_enter) begin
      cpu_clk_en <= 1'b0;
    end
  end

  // ==========================================================
  // Vector fetch: even byte first, it is the high half
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prog_addr <= 16'h0000;
      prog_rd   <= 1'b0;
      vec_hi    <= 8'h00;
    end else begin
      prog_rd <= save_step | hi_step;
      if (save_step) begin
        prog_addr <= vec_base;
      end
      if (hi_step) begin
        vec_hi    <= prog_data;
        prog_addr <= vec_base + `VIH_VEC_STEP / 2;
      end
    end
  end

  // ==========================================================
  // Branch to the service routine; the address holds until the next branch
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      branch_go   <= 1'b0;
      branch_addr <= 16'h0000;
    end else begin
      branch_go <= lo_step;
      if (lo_step) begin
        branch_addr <= {vec_hi, prog_data};
      end
    end
  end

  // ==========================================================
  // Register writes; hardware set wins over software clear
  wire wr_req;
  wire wr_mask;
  wire wr_prio;
  wire wr_p3m;
  assign wr_req  = reg_wr && (reg_addr == `VIH_REQ_REG_ADDR);
  assign wr_mask = reg_wr && (reg_addr == `VIH_MASK_REG_ADDR);
  assign wr_prio = reg_wr && (reg_addr == `VIH_PRIO_REG_ADDR);
  assign wr_p3m  = reg_wr && (reg_addr == `VIH_PORT3_MODE_ADDR);

  // A request arriving during a software write still lands
  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      req_reg <= `VIH_REQ_RESET;
    end else if (wr_req) begin
      req_reg <= {reg_wdata[7:6], (reg_wdata[5:0] & ~clr_mask) | hit};
    end else begin
      req_reg[5:0] <= (req_reg[5:0] & ~clr_mask) | hit;
    end
  end

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mask_reg <= `VIH_MASK_RESET;
    end else if (wr_mask) begin
      mask_reg <= reg_wdata;
    end
  end

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prio_reg <= `VIH_PRIO_RESET;
    end else if (wr_prio) begin
      prio_reg <= {5'h00, reg_wdata[2:0]};
    end
  end

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      port3_mode_reg <= `VIH_P3M_RESET;
    end else if (wr_p3m) begin
      port3_mode_reg <= reg_wdata;
    end
  end

  // ==========================================================
  // Reads: data stands in the cycle after the strobe, zero otherwise
  reg [7:0] next_rdata;
  always @* begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `VIH_REQ_REG_ADDR:    next_rdata = req_reg;
        `VIH_MASK_REG_ADDR:   next_rdata = mask_reg;
        `VIH_PRIO_REG_ADDR:   next_rdata = prio_reg;
        `VIH_PORT3_MODE_ADDR: next_rdata = port3_mode_reg;
        `VIH_PIN_STATE_ADDR:  next_rdata = {5'h00, port3_3, port3_2, port3_1};
        default:              next_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule

/* vih_core_model.sv */
// Core sequencer and vector memory facing the controller
// Assumes the controller's clock; memory answers combinationally
`timescale 1ns/100ps
// ==========================================
// Sequencer model
module vih_core_model (
  input  wire        clk_sys,
  input  wire        slow,
  input  wire [15:0] prog_addr,
  input  wire        branch_go,
  output logic       ack_step,
  output logic [7:0] prog_data,
  output logic       iret_done
);
  logic [1:0] div = 2'h0;
  logic [2:0] ret_cnt = 3'h0;
  // Slow mode steps only every fourth cycle
  assign ack_step = !slow || (div == 2'h0);
  // Even byte is the high half of the service address
  assign prog_data = prog_addr[0] ? {4'h0, prog_addr[3:0]} : 8'hc3;
  initial iret_done = 1'b0;
  always @(posedge clk_sys) begin
    div <= div + 2'h1;
    iret_done <= (ret_cnt == 3'h1);
    if (branch_go)
      ret_cnt <= 3'h6;
    else if (ret_cnt != 3'h0)
      ret_cnt <= ret_cnt - 3'h1;
  end
endmodule

/* vih_ctrl_asserts.sv */
// Port checker for the vectored interrupt controller
// Assumes one clock domain; bound to every controller instance
`timescale 1ns/100ps
// ==========================================
// Properties
module vih_ctrl_asserts (
  input wire        clk_sys,
  input wire        rst_n,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire        iret_done,
  input wire [15:0] prog_addr,
  input wire        prog_rd,
  input wire        save_ctx,
  input wire        branch_go,
  input wire [15:0] branch_addr,
  input wire        cpu_clk_en,
  input wire        int_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_save_on_grant: assert property ($rose(int_active) |-> save_ctx)
    else $error("grant without save");
  a_save_in_service: assert property (save_ctx |-> int_active [*3])
    else $error("save outside service");
  a_no_regrant: assert property (int_active && !iret_done |=> !save_ctx)
    else $error("second grant in service");
  a_fetch_pair: assert property (prog_rd && !prog_addr[0] |-> ##[1:20] (prog_rd && prog_addr[0]))
    else $error("odd vector byte missing");
  a_vector_range: assert property (prog_rd |-> int_active && prog_addr < 16'h000c)
    else $error("vector fetch out of range");
  a_branch_hold: assert property (branch_go |=> $stable(branch_addr))
    else $error("branch address moved");
  a_read_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
  a_wake_on_int: assert property ($rose(cpu_clk_en) |-> ##[0:2] int_active)
    else $error("wake without interrupt");
endmodule
bind vih_ctrl vih_ctrl_asserts u_chk (.clk_sys, .rst_n, .reg_rd, .reg_rdata, .iret_done, .prog_addr,
  .prog_rd, .save_ctx, .branch_go, .branch_addr, .cpu_clk_en, .int_active);

/* vih_ctrl_test.sv */
// Self-checking bench for the vectored interrupt controller
// Assumes the sequencer model and the checker are compiled before it
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end
// ==========================================
// Bench top
module vih_ctrl_test;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, slow = 0, halt_req = 0;
  logic port3_1 = 1, port3_2 = 1, port3_3 = 1, stop_recovery_out = 1, analog_in_one = 1, analog_in_two = 1;
  logic wide_timer = 0, narrow_timer = 0, low_voltage_detect = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  wire [7:0] reg_rdata, prog_data;
  wire [15:0] prog_addr, branch_addr;
  wire ack_step, iret_done, prog_rd, save_ctx, branch_go, cpu_clk_en, int_active;
  int fails = 0, check_count = 0;
  vih_ctrl dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port3_1, .port3_2,
    .port3_3, .stop_recovery_out, .analog_in_one, .analog_in_two, .wide_timer, .narrow_timer,
    .low_voltage_detect, .halt_req, .iret_done, .ack_step, .prog_data, .prog_addr, .prog_rd, .save_ctx,
    .branch_go, .branch_addr, .cpu_clk_en, .int_active);
  vih_core_model core (.clk_sys, .slow, .prog_addr, .branch_go, .ack_step, .prog_data, .iret_done);
  initial forever #50 clk_sys = ~clk_sys;
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, d);
    tick(1);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    tick(1);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e, input string n);
    tick(1);
    {reg_rd, reg_addr} <= {1'b1, a};
    tick(1);
    reg_rd <= 1'b0;
    #1 `CHK(n, e, reg_rdata)
  endtask
  // Pins stay low until the service ends
  task automatic fire(input int k);
    tick(1);
    case (k)
      0: port3_2 <= 0;
      1: port3_3 <= 0;
      2: port3_1 <= 0;
      3: wide_timer <= 1;
      4: narrow_timer <= 1;
      default: low_voltage_detect <= 1;
    endcase
    tick(1);
    {wide_timer, narrow_timer, low_voltage_detect} <= 3'h0;
  endtask
  task automatic serve(input int k);
    int i;
    #1;
    for (i = 0; i < 60 && branch_go !== 1'b1; i++) @(posedge clk_sys) #1;
    if (i == 60) begin fails++; final_report(); end
    `CHK("branch", {8'hc3, 8'(2 * k + 1)}, branch_addr)
    for (i = 0; i < 60 && int_active !== 1'b0; i++) tick(1);
    if (i == 60) begin fails++; final_report(); end
    {port3_1, port3_2, port3_3} <= 3'h7;
  endtask
  task automatic t_regs;
    rd(8'hfa, 8'h00, "request");
    rd(8'hfb, 8'h00, "mask");
    rd(8'hf6, 8'h07, "pins");
    rd(8'he0, 8'h00, "unmapped");
    wr(8'hf9, 8'h05);
    rd(8'hf9, 8'h05, "priority");
    wr(8'hf9, 8'h00);
  endtask
  task automatic t_vectors;
    for (int k = 0; k < 6; k++) begin
      wr(8'hfb, 8'h80 | (8'h01 << k));
      fire(k);
      serve(k);
      rd(8'hfa, 8'h00, "flag cleared");
    end
  endtask
  task automatic t_edges;
    logic [1:0] c;
    wr(8'hfb, 8'h00);
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(8'hfa, {c, 6'h00});
      tick(1);
      {port3_2, port3_1} <= 2'h0;
      tick(3);
      rd(8'hfa, {c, 3'h0, !c[1] | c[0], 1'b0, !c[0] | c[1]}, "falling");
      rd(8'hf6, 8'h04, "low pins");
      wr(8'hfa, {c, 6'h00});
      {port3_2, port3_1} <= 2'h3;
      tick(3);
      rd(8'hfa, {c, 3'h0, c[1], 1'b0, c[0]}, "rising");
      wr(8'hfa, 8'h00);
    end
  endtask
  task automatic t_sources;
    {analog_in_one, analog_in_two} <= 2'h0;
    tick(3);
    rd(8'hfa, 8'h05, "analog");
    tick(1);
    {analog_in_one, analog_in_two} <= 2'h3;
    wr(8'hfa, 8'h00);
    wr(8'hf7, 8'h02);
    port3_3 <= 0;
    tick(3);
    rd(8'hfa, 8'h00, "pin ignored");
    tick(1);
    stop_recovery_out <= 0;
    tick(3);
    rd(8'hfa, 8'h02, "recovery source");
    tick(1);
    {port3_3, stop_recovery_out} <= 2'h3;
    wr(8'hfa, 8'h00);
    wr(8'hf7, 8'h00);
  endtask
  task automatic t_priority;
    slow <= 1;
    wr(8'hfb, 8'h3f);
    fire(3);
    fire(4);
    tick(3);
    rd(8'hfa, 8'h18, "polled");
    `CHK("masked", 1'b0, int_active)
    wr(8'hf9, 8'h04);
    wr(8'hfb, 8'hbf);
    serve(4);
    serve(3);
    wr(8'hf9, 8'h00);
    slow <= 0;
  endtask
  task automatic t_halt;
    // Idle bus cycle stands in for the flushing no-op
    wr(8'hfb, 8'h80);
    halt_req <= 1;
    tick(1);
    halt_req <= 0;
    tick(3);
    #1 `CHK("halted", 1'b0, cpu_clk_en)
    fire(3);
    tick(4);
    #1 `CHK("still halted", 1'b0, cpu_clk_en)
    rd(8'hfa, 8'h08, "timer in halt");
    wr(8'hfb, 8'h88);
    serve(3);
    `CHK("woken", 1'b1, cpu_clk_en)
  endtask
  initial begin
    tick(4);
    rst_n <= 1;
    tick(3);
    t_regs();
    t_vectors();
    t_edges();
    t_sources();
    t_priority();
    t_halt();
    final_report();
  end
endmodule
